// [hw/dcpio_bank.sv]
// Pad register bank shared by two processor cores
// What this block does
// - Core number reads 0 from the first core, 1 from the second.
// - General input register returns 30 sampled pads, top bits zero.
// - Flash input register returns six pads: clock, select, data 0-3.
// - General level bits drive pads high or low; reset to zero.
// - Level and enable registers read back written value, not pads.
// - Same-cycle writes: first core applied, then second on result.
// - Level set alias ORs written value into the level register.
// - Level clear alias clears bits written as one.
// - Level toggle alias XORs written value into the level register.
// - General enable bits make pads outputs; reset to zero.
// - Enable set alias ORs written value into the enable register.
// - Enable clear alias clears bits written as one.
// - Enable toggle alias XORs written value into the enable register.
// - Flash level bits drive flash pads high or low; reset zero.
`timescale 1ns/1ns
module dcpio_bank
    import dcpio_pkg::*;
#(
    parameter int GEN_PADS = GENERAL_PADS,
    parameter int FL_PADS = FLASH_PADS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // First core register port
    input wire dcpio_req_t core0_req,
    output logic [31:0] core0_rdata,
    // Second core register port
    input wire dcpio_req_t core1_req,
    output logic [31:0] core1_rdata,
    // Pads
    input wire logic [GEN_PADS-1:0] general_pad_in,
    input wire dcpio_flash_t flash_pad_in,
    output logic [GEN_PADS-1:0] general_pad_out,
    output logic [GEN_PADS-1:0] general_pad_oe,
    output dcpio_flash_t flash_pad_out
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // At least one reserved bit is kept so zero padding stays legal
    if (GEN_PADS < 1 || GEN_PADS > 31) begin : g_bad_gen
        $error("GEN_PADS must lie between 1 and 31");
    end
    if (FL_PADS != $bits(dcpio_flash_t)) begin : g_bad_flash
        $error("FL_PADS must match the flash pad layout");
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic dcpio_op_t decode_op(
        input dcpio_req_t req,
        input logic [11:0] base
    );
        dcpio_op_t op;
        op = DCPIO_OP_NONE;
        if (!req.wr) begin
            op = DCPIO_OP_NONE;
        end else if (req.addr == base) begin
            op = DCPIO_OP_WRITE;
        end else if (req.addr == base + ALIAS_SET) begin
            op = DCPIO_OP_SET;
        end else if (req.addr == base + ALIAS_CLEAR) begin
            op = DCPIO_OP_CLEAR;
        end else if (req.addr == base + ALIAS_TOGGLE) begin
            op = DCPIO_OP_TOGGLE;
        end
        return op;
    endfunction : decode_op

    function automatic logic [31:0] apply_op(
        input logic [31:0] cur,
        input dcpio_op_t op,
        input logic [31:0] data
    );
        logic [31:0] res;
        res = cur;
        case (op)
            DCPIO_OP_WRITE: begin
                res = data;
            end
            DCPIO_OP_SET: begin
                res = cur | data;
            end
            DCPIO_OP_CLEAR: begin
                res = cur & ~data;
            end
            DCPIO_OP_TOGGLE: begin
                res = cur ^ data;
            end
            default: begin
                res = cur;
            end
        endcase
        return res;
    endfunction : apply_op

    // ************************************************************
    // Register state
    // ************************************************************
    logic [GEN_PADS-1:0] level;
    logic [GEN_PADS-1:0] enable;
    dcpio_flash_t flash_level;
    logic [31:0] level_wide;
    logic [31:0] enable_wide;
    logic [31:0] flash_wide;
    logic [31:0] level_after0;
    logic [31:0] level_after1;
    logic [31:0] enable_after0;
    logic [31:0] enable_after1;
    logic [31:0] flash_after0;
    logic [31:0] flash_after1;
    logic [GEN_PADS-1:0] next_level;
    logic [GEN_PADS-1:0] next_enable;
    dcpio_flash_t next_flash_level;

    assign level_wide = {{(32 - GEN_PADS){1'b0}}, level};
    assign enable_wide = {{(32 - GEN_PADS){1'b0}}, enable};
    assign flash_wide = {{(32 - FL_PADS){1'b0}}, flash_level};

    // Core 0 first, core 1 on its result, all in one cycle
    assign level_after0 = apply_op(level_wide,
        decode_op(core0_req, OFF_GENERAL_PAD_LEVEL), core0_req.wdata);
    assign level_after1 = apply_op(level_after0,
        decode_op(core1_req, OFF_GENERAL_PAD_LEVEL), core1_req.wdata);
    assign enable_after0 = apply_op(enable_wide,
        decode_op(core0_req, OFF_GENERAL_DRIVE_ENABLE),
        core0_req.wdata);
    assign enable_after1 = apply_op(enable_after0,
        decode_op(core1_req, OFF_GENERAL_DRIVE_ENABLE),
        core1_req.wdata);

    // Flash level has no aliases here; a plain write stands
    assign flash_after0 = (core0_req.wr
        && core0_req.addr == OFF_FLASH_PAD_LEVEL) ? core0_req.wdata
        : flash_wide;
    assign flash_after1 = (core1_req.wr
        && core1_req.addr == OFF_FLASH_PAD_LEVEL) ? core1_req.wdata
        : flash_after0;

    // Upper bits dropped so reserved positions never store
    assign next_level = level_after1[GEN_PADS-1:0];
    assign next_enable = enable_after1[GEN_PADS-1:0];
    assign next_flash_level = dcpio_flash_t'(flash_after1[FL_PADS-1:0]);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            level <= RESET_GENERAL_LEVEL[GEN_PADS-1:0];
        end else begin
            level <= next_level;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            enable <= RESET_GENERAL_ENABLE[GEN_PADS-1:0];
        end else begin
            enable <= next_enable;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flash_level <= dcpio_flash_t'(RESET_FLASH_LEVEL[5:0]);
        end else begin
            flash_level <= next_flash_level;
        end
    end

    // ************************************************************
    // Pad drive
    // ************************************************************
    assign general_pad_out = level;
    assign general_pad_oe = enable;
    assign flash_pad_out = flash_level;

    // ************************************************************
    // Read path
    // ************************************************************
    // Reads see the value before any write of the same cycle
    function automatic logic [31:0] read_mux(
        input logic [11:0] addr,
        input logic [31:0] core_id,
        input logic [31:0] gen_in,
        input logic [31:0] fl_in,
        input logic [31:0] lvl,
        input logic [31:0] oe,
        input logic [31:0] fl_lvl
    );
        logic [31:0] res;
        res = UNMAPPED_READ;
        if (addr == OFF_CORE_NUMBER) begin
            res = core_id;
        end else if (addr == OFF_GENERAL_PAD_INPUTS) begin
            res = gen_in;
        end else if (addr == OFF_FLASH_PAD_INPUTS) begin
            res = fl_in;
        end else if (addr == OFF_GENERAL_PAD_LEVEL) begin
            res = lvl;
        end else if (addr == OFF_GENERAL_DRIVE_ENABLE) begin
            res = oe;
        end else if (addr == OFF_FLASH_PAD_LEVEL) begin
            res = fl_lvl;
        end
        return res;
    endfunction : read_mux

    logic [31:0] gen_in_wide;
    logic [31:0] flash_in_wide;

    assign gen_in_wide = {{(32 - GEN_PADS){1'b0}}, general_pad_in};
    assign flash_in_wide = {{(32 - FL_PADS){1'b0}}, flash_pad_in};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            core0_rdata <= UNMAPPED_READ;
        end else if (core0_req.rd) begin
            core0_rdata <= read_mux(core0_req.addr, CORE0_NUMBER,
                gen_in_wide, flash_in_wide, level_wide, enable_wide,
                flash_wide);
        end else begin
            core0_rdata <= UNMAPPED_READ;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            core1_rdata <= UNMAPPED_READ;
        end else if (core1_req.rd) begin
            core1_rdata <= read_mux(core1_req.addr, CORE1_NUMBER,
                gen_in_wide, flash_in_wide, level_wide, enable_wide,
                flash_wide);
        end else begin
            core1_rdata <= UNMAPPED_READ;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    logic c0_lvl_set;
    logic c0_lvl_clr;
    logic c0_lvl_tog;
    logic c1_lvl_any;
    logic c0_oe_any;
    logic c1_oe_any;
    logic [GEN_PADS-1:0] wd0;
    logic [GEN_PADS-1:0] wd1;

    assign c0_lvl_set = core0_req.wr
        && core0_req.addr == OFF_GENERAL_LEVEL_SET;
    assign c0_lvl_clr = core0_req.wr
        && core0_req.addr == OFF_GENERAL_LEVEL_CLEAR;
    assign c0_lvl_tog = core0_req.wr
        && core0_req.addr == OFF_GENERAL_LEVEL_TOGGLE;
    assign c1_lvl_any = core1_req.wr
        && core1_req.addr[11:4] == OFF_GENERAL_PAD_LEVEL[11:4];
    assign c0_oe_any = core0_req.wr
        && core0_req.addr[11:4] == OFF_GENERAL_DRIVE_ENABLE[11:4];
    assign c1_oe_any = core1_req.wr
        && core1_req.addr[11:4] == OFF_GENERAL_DRIVE_ENABLE[11:4];
    assign wd0 = core0_req.wdata[GEN_PADS-1:0];
    assign wd1 = core1_req.wdata[GEN_PADS-1:0];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_core_id0;
        core0_req.rd && core0_req.addr == OFF_CORE_NUMBER
            |=> core0_rdata == CORE0_NUMBER;
    endproperty
    a_core_id0: assert property (p_core_id0)
        else $error("first core read wrong core number");

    property p_core_id1;
        core1_req.rd && core1_req.addr == OFF_CORE_NUMBER
            |=> core1_rdata == CORE1_NUMBER;
    endproperty
    a_core_id1: assert property (p_core_id1)
        else $error("second core read wrong core number");

    property p_gen_in;
        core0_req.rd && core0_req.addr == OFF_GENERAL_PAD_INPUTS
            |=> core0_rdata == {{(32 - GEN_PADS){1'b0}},
                $past(general_pad_in)};
    endproperty
    a_gen_in: assert property (p_gen_in)
        else $error("general input read mismatch");

    property p_flash_in;
        core1_req.rd && core1_req.addr == OFF_FLASH_PAD_INPUTS
            |=> core1_rdata[5:0] == $past(flash_pad_in)
                && core1_rdata[31:6] == 26'h0000000;
    endproperty
    a_flash_in: assert property (p_flash_in)
        else $error("flash input read mismatch");

    property p_drive_follows;
        ##1 general_pad_out == level && general_pad_oe == enable
            && flash_pad_out == flash_level;
    endproperty
    a_drive_follows: assert property (p_drive_follows)
        else $error("pad drive differs from registers");

    property p_readback;
        core0_req.rd && core0_req.addr == OFF_GENERAL_PAD_LEVEL
            && !core1_req.wr
            ##1 !core0_req.wr && !core1_req.wr && core0_req.rd
            && core0_req.addr == OFF_GENERAL_PAD_LEVEL
            |=> core0_rdata == $past(core0_rdata, 1);
    endproperty
    a_readback: assert property (p_readback)
        else $error("level read back changed with no write");

    property p_merge_direct;
        core0_req.wr && core1_req.wr
            && core0_req.addr == OFF_GENERAL_PAD_LEVEL
            && core1_req.addr == OFF_GENERAL_PAD_LEVEL
            |=> level == $past(wd1);
    endproperty
    a_merge_direct: assert property (p_merge_direct)
        else $error("second core write did not land last");

    property p_merge_set_clr;
        c0_lvl_set && core1_req.wr
            && core1_req.addr == OFF_GENERAL_LEVEL_CLEAR
            |=> level == (($past(level) | $past(wd0)) & ~$past(wd1));
    endproperty
    a_merge_set_clr: assert property (p_merge_set_clr)
        else $error("merge order of set and clear wrong");

    property p_lvl_set;
        c0_lvl_set && !c1_lvl_any |=> level == ($past(level) | $past(wd0));
    endproperty
    a_lvl_set: assert property (p_lvl_set)
        else $error("level set alias wrong");

    property p_lvl_clr;
        c0_lvl_clr && !c1_lvl_any
            |=> level == ($past(level) & ~$past(wd0));
    endproperty
    a_lvl_clr: assert property (p_lvl_clr)
        else $error("level clear alias wrong");

    property p_lvl_tog;
        c0_lvl_tog && !c1_lvl_any
            ##1 c0_lvl_tog && !c1_lvl_any && wd0 == $past(wd0)
            |=> level == $past(level, 2);
    endproperty
    a_lvl_tog: assert property (p_lvl_tog)
        else $error("double toggle did not restore level");

    property p_oe_set;
        core1_req.wr && core1_req.addr == OFF_GENERAL_DRIVE_ENABLE_SET
            && !c0_oe_any |=> enable == ($past(enable) | $past(wd1));
    endproperty
    a_oe_set: assert property (p_oe_set)
        else $error("enable set alias wrong");

    property p_oe_clr;
        core1_req.wr && core1_req.addr == OFF_GENERAL_DRIVE_ENABLE_CLEAR
            && !c0_oe_any |=> enable == ($past(enable) & ~$past(wd1));
    endproperty
    a_oe_clr: assert property (p_oe_clr)
        else $error("enable clear alias wrong");

    property p_oe_tog;
        core1_req.wr && core1_req.addr == OFF_GENERAL_DRIVE_ENABLE_TOGGLE
            && !c0_oe_any |=> enable == ($past(enable) ^ $past(wd1));
    endproperty
    a_oe_tog: assert property (p_oe_tog)
        else $error("enable toggle alias wrong");

    property p_oe_hold;
        !c0_oe_any && !c1_oe_any |=> $stable(enable);
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("enable changed with no write");

    property p_flash_wr;
        core0_req.wr && core0_req.addr == OFF_FLASH_PAD_LEVEL
            && !(core1_req.wr && core1_req.addr == OFF_FLASH_PAD_LEVEL)
            |=> flash_pad_out == $past(core0_req.wdata[5:0]);
    endproperty
    a_flash_wr: assert property (p_flash_wr)
        else $error("flash level write not driven");

    property p_reserved;
        core0_rdata[31:30] == 2'h0 && core1_rdata[31:30] == 2'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved read bits not zero");

    property p_idle_read;
        !core0_req.rd |=> core0_rdata == UNMAPPED_READ;
    endproperty
    a_idle_read: assert property (p_idle_read)
        else $error("read data held past its cycle");

    cover property (core0_req.wr && core1_req.wr
        && c1_lvl_any && core0_req.addr[11:4] == 8'h01);
    cover property (c0_oe_any && c1_oe_any);
    cover property (c0_lvl_tog ##1 core0_req.rd
        && core0_req.addr == OFF_GENERAL_PAD_LEVEL);
    cover property (core1_req.rd && core1_req.addr == OFF_CORE_NUMBER);

endmodule : dcpio_bank

// [hw/dcpio_pkg.sv]
// Package with the register map, field layouts and carriers of the pad bank
package dcpio_pkg;

    // ************************************************************
    // Register offsets, byte addresses
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFF_CORE_NUMBER = 12'h000;
    localparam logic [11:0] OFF_GENERAL_PAD_INPUTS = 12'h004;
    localparam logic [11:0] OFF_FLASH_PAD_INPUTS = 12'h008;
    localparam logic [11:0] OFF_GENERAL_PAD_LEVEL = 12'h010;
    localparam logic [11:0] OFF_GENERAL_LEVEL_SET = 12'h014;
    localparam logic [11:0] OFF_GENERAL_LEVEL_CLEAR = 12'h018;
    localparam logic [11:0] OFF_GENERAL_LEVEL_TOGGLE = 12'h01C;
    localparam logic [11:0] OFF_GENERAL_DRIVE_ENABLE = 12'h020;
    localparam logic [11:0] OFF_GENERAL_DRIVE_ENABLE_SET = 12'h024;
    localparam logic [11:0] OFF_GENERAL_DRIVE_ENABLE_CLEAR = 12'h028;
    localparam logic [11:0] OFF_GENERAL_DRIVE_ENABLE_TOGGLE = 12'h02C;
    localparam logic [11:0] OFF_FLASH_PAD_LEVEL = 12'h030;

    // Alias spacing from a register's direct offset
    localparam logic [11:0] ALIAS_SET = 12'h004;
    localparam logic [11:0] ALIAS_CLEAR = 12'h008;
    localparam logic [11:0] ALIAS_TOGGLE = 12'h00C;

    // ************************************************************
    // Widths, reset values and fixed answers
    // ************************************************************
    localparam int GENERAL_PADS = 30;
    localparam int FLASH_PADS = 6;
    localparam logic [31:0] RESET_GENERAL_LEVEL = 32'h0000_0000;
    localparam logic [31:0] RESET_GENERAL_ENABLE = 32'h0000_0000;
    localparam logic [31:0] RESET_FLASH_LEVEL = 32'h0000_0000;
    localparam logic [31:0] CORE0_NUMBER = 32'h0000_0000;
    localparam logic [31:0] CORE1_NUMBER = 32'h0000_0001;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        DCPIO_OP_NONE = 3'b000,
        DCPIO_OP_WRITE = 3'b001,
        DCPIO_OP_SET = 3'b010,
        DCPIO_OP_CLEAR = 3'b011,
        DCPIO_OP_TOGGLE = 3'b100
    } dcpio_op_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dcpio_req_t;

    // Bit 0 is the serial clock, bit 5 data line 3
    typedef struct packed {
        logic flash_data_line3;
        logic flash_data_line2;
        logic flash_data_line1;
        logic flash_data_line0;
        logic flash_chip_select_n;
        logic serial_clock;
    } dcpio_flash_t;

endpackage : dcpio_pkg

// [testbench/dcpio_pad_model.sv]
// Pad-side model: outside-world levels mixed with the pads the bank drives
`timescale 1ns/1ns
module dcpio_pad_model
    import dcpio_pkg::*;
(
    // From the bank
    input wire logic [29:0] pad_out,
    input wire logic [29:0] pad_oe,
    // Levels the outside world puts on undriven pads
    input wire logic [29:0] world_gen,
    input wire dcpio_flash_t world_flash,
    // To the bank
    output logic [29:0] general_pad_in,
    output dcpio_flash_t flash_pad_in
);
    // ************************************************************
    // Wire levels
    // ************************************************************
    // A driven pad reads back its own level; contention is not modelled
    always_comb begin
        general_pad_in = (pad_out & pad_oe) | (world_gen & ~pad_oe);
        // No flash drive enable exists, so the world always owns them
        flash_pad_in = world_flash;
    end
endmodule : dcpio_pad_model

// [testbench/dual_core_pad_io_regs_tb_top.sv]
// Self-checking bench for the dual-core pad register bank
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("BAD %0t got %h exp %h", $time, got, exp); \
        end \
    end
module dual_core_pad_io_regs_tb_top
    import dcpio_pkg::*;
;
    // ************************************************************
    // Signals and model state
    // ************************************************************
    localparam logic [31:0] GMASK = 32'h3FFF_FFFF;
    localparam logic [31:0] FMASK = 32'h0000_003F;
    logic clk = 1'b0;
    logic reset = 1'b1;
    dcpio_req_t core0_req = '0;
    dcpio_req_t core1_req = '0;
    logic [31:0] core0_rdata, core1_rdata;
    logic [29:0] general_pad_in, general_pad_out, general_pad_oe;
    logic [29:0] world_gen = 30'h0;
    dcpio_flash_t flash_pad_in, flash_pad_out;
    dcpio_flash_t world_flash = '0;
    int n_fail = 0;
    int comparisons = 0;
    int seed = 17711;
    logic [31:0] m_lvl, m_oe, m_fl, rd0, rd1;
    logic [11:0] wr_addrs [12] = '{12'h010, 12'h014, 12'h018, 12'h01C,
        12'h020, 12'h024, 12'h028, 12'h02C, 12'h030, 12'h000, 12'h004,
        12'h034};
    logic [11:0] rd_addrs [8] = '{12'h000, 12'h004, 12'h008, 12'h010,
        12'h020, 12'h030, 12'h00C, 12'hFFC};

    always #2 clk = ~clk;

    dcpio_bank #(.GEN_PADS(30), .FL_PADS(6)) DUT (
        .clk(clk), .reset(reset),
        .core0_req(core0_req), .core0_rdata(core0_rdata),
        .core1_req(core1_req), .core1_rdata(core1_rdata),
        .general_pad_in(general_pad_in), .flash_pad_in(flash_pad_in),
        .general_pad_out(general_pad_out), .general_pad_oe(general_pad_oe),
        .flash_pad_out(flash_pad_out)
    );

    dcpio_pad_model pads (
        .pad_out(general_pad_out), .pad_oe(general_pad_oe),
        .world_gen(world_gen), .world_flash(world_flash),
        .general_pad_in(general_pad_in), .flash_pad_in(flash_pad_in)
    );

    // ************************************************************
    // Expectation functions
    // ************************************************************
    function automatic dcpio_req_t mk(input logic [11:0] a,
        input logic [31:0] d, input logic w, input logic r);
        return '{addr: a, wdata: d, wr: w, rd: r};
    endfunction : mk

    // Direct write, then set, clear and toggle aliases at 4, 8 and C
    function automatic logic [31:0] upd(input logic [31:0] cur,
        input logic [11:0] base, input dcpio_req_t r);
        logic [31:0] d;
        d = r.wdata & GMASK;
        if (!r.wr) return cur;
        case (r.addr - base)
            12'h000: return d;
            12'h004: return cur | d;
            12'h008: return cur & ~d;
            12'h00C: return cur ^ d;
            default: return cur;
        endcase
    endfunction : upd

    function automatic logic [31:0] exp_rd(input logic [11:0] a,
        input logic [31:0] id);
        case (a)
            OFF_CORE_NUMBER: return id;
            OFF_GENERAL_PAD_INPUTS: return {2'b00, (m_lvl[29:0] &
                m_oe[29:0]) | (world_gen & ~m_oe[29:0])};
            OFF_FLASH_PAD_INPUTS: return {26'h0, world_flash};
            OFF_GENERAL_PAD_LEVEL: return m_lvl;
            OFF_GENERAL_DRIVE_ENABLE: return m_oe;
            OFF_FLASH_PAD_LEVEL: return m_fl;
            default: return 32'h0000_0000;
        endcase
    endfunction : exp_rd

    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic model(input dcpio_req_t r);
        m_lvl = upd(m_lvl, OFF_GENERAL_PAD_LEVEL, r);
        m_oe = upd(m_oe, OFF_GENERAL_DRIVE_ENABLE, r);
        if (r.wr && r.addr == OFF_FLASH_PAD_LEVEL) m_fl = r.wdata & FMASK;
    endtask : model

    // Both ports in one cycle; core 0 is folded into the model first
    task automatic bus(input dcpio_req_t r0, input dcpio_req_t r1);
        core0_req <= r0;
        core1_req <= r1;
        @(posedge clk);
        core0_req <= '0;
        core1_req <= '0;
        #1;
        rd0 = core0_rdata;
        rd1 = core1_rdata;
        model(r0);
        model(r1);
    endtask : bus

    task automatic chk_outs();
        `CHK(general_pad_out, m_lvl[29:0])
        `CHK(general_pad_oe, m_oe[29:0])
        `CHK(flash_pad_out, dcpio_flash_t'(m_fl[5:0]))
    endtask : chk_outs

    task automatic rd(input logic [11:0] a0, input logic [11:0] a1);
        bus(mk(a0, 32'h0, 1'b0, 1'b1), mk(a1, 32'h0, 1'b0, 1'b1));
        `CHK(rd0, exp_rd(a0, CORE0_NUMBER))
        `CHK(rd1, exp_rd(a1, CORE1_NUMBER))
    endtask : rd

    task automatic do_reset();
        reset <= 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        m_lvl = 32'h0;
        m_oe = 32'h0;
        m_fl = 32'h0;
        @(posedge clk);
        #1;
    endtask : do_reset

    task automatic give_verdict();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int i0;
        int i1;
        do_reset();
        chk_outs();
        world_gen <= 30'h2AAA_5555;
        world_flash <= 6'h25;
        for (int i = 0; i < 8; i++) begin
            rd(rd_addrs[i], rd_addrs[7 - i]);
        end
        // Read data stands for one cycle only
        @(posedge clk);
        #1;
        `CHK(core0_rdata, 32'h0000_0000)
        // Same-cycle writes where order changes the result
        bus(mk(12'h014, 32'h0000_000F, 1, 0), mk(12'h018, 32'h5, 1, 0));
        chk_outs();
        bus(mk(12'h010, 32'hFFFF_FFFF, 1, 0), mk(12'h01C, 32'h1, 1, 0));
        chk_outs();
        bus(mk(12'h028, 32'hFFFF_FFFF, 1, 0), mk(12'h024, 32'h3, 1, 0));
        chk_outs();
        bus(mk(12'h030, 32'hFFFF_FFFF, 1, 0), mk(12'h030, 32'h2A, 1, 0));
        chk_outs();
        for (int n = 0; n < 400; n++) begin
            i0 = $unsigned($random(seed)) % 12;
            i1 = (n % 3 == 0) ? i0 : $unsigned($random(seed)) % 12;
            world_gen <= 30'($random(seed));
            world_flash <= dcpio_flash_t'(6'($random(seed)));
            bus(mk(wr_addrs[i0], $random(seed), 1, 0),
                mk(wr_addrs[i1], $random(seed), 1, 0));
            chk_outs();
            i0 = $unsigned($random(seed)) % 8;
            i1 = $unsigned($random(seed)) % 8;
            rd(rd_addrs[i0], rd_addrs[i1]);
        end
        // Second reset in mid-run must clear every output register
        do_reset();
        chk_outs();
        rd(12'h010, 12'h020);
        rd(12'h030, 12'h000);
        give_verdict();
    end

    // Guards against a stuck run
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        $display("BAD %0t run did not finish", $time);
        give_verdict();
    end
endmodule : dual_core_pad_io_regs_tb_top
